// File: verilog/hub_boot_strap_sequencer.sv
// boot stage sequencer: flash signature check, strap decode, config wait
// assumes an AXI4-Lite master on i_sys_clk and strap levels from pin sense
// Contract
// - each port has a plus and minus line strap, 1 disables that line
// - a port is disabled only when both its line straps are high
// - a port disabled on the USB 2.0 side also loses its USB 3 side
// - fixed-device strap codes decode to none, 1, 1-2, 1-3, 1-4, all
// - charging strap codes decode to none, 1, 1-2, 1-3, 1-4, all
// - each general pin is input or output, inputs may pick pull up/down
// - general pin registers are writable only once booted
// - while reset is low stay in standby with all pins released
// - standby drops all state and restores every register default
// - on release, wait for clock lock and load defaults
// - strapped flash boot reads signature at FFFA, match enables ext rom
// - no signature or no flash strap continues to configuration read
// - the flash master works with mode 0 and mode 3 parts
// - configuration read loads defaults then overrides from straps
// - option 2 senses bus pins, both pulled up enters controller config
// - option 2 enables slave mode and speed indicator pins
// - controller config waits without limit for a write to index FF
`timescale 1ns/1ps
`default_nettype none
`include "hub_boot_defines.svh"
module hub_boot_strap_sequencer #(
  parameter int NG       = 8,
  parameter int SPI_HALF = 4
) (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_n,
  input  wire logic [5:0]                 i_port_plus_line_off_strap,
  input  wire logic [5:0]                 i_port_minus_line_off_strap,
  input  wire logic [2:0]                 i_fixed_device_ports_strap,
  input  wire logic [2:0]                 i_charging_ports_strap,
  input  wire logic [2:0]                 i_config_select_strap,
  input  wire logic                       i_flash_boot_strap,
  input  wire logic                       i_mgmt_bus_data_pin,
  input  wire logic                       i_mgmt_bus_clock_pin,
  input  wire logic                       i_pll_locked,
  input  wire logic                       i_flash_miso,
  input  wire logic [NG-1:0]              i_general_pin_n,
  output var  logic                       o_flash_cs_n,
  output var  logic                       o_flash_sclk,
  output var  logic                       o_flash_mosi,
  output var  logic                       o_ext_rom_en,
  output var  hub_boot_pkg::boot_stage_type o_stage,
  output var  logic                       o_config_done,
  output var  logic                       o_mgmt_slave_en,
  output var  logic                       o_speed_ind_en,
  output var  logic [5:0]                 o_usb2_port_off,
  output var  logic [5:0]                 o_usb3_port_off,
  output var  logic [5:0]                 o_fixed_ports,
  output var  logic [5:0]                 o_charging_ports,
  output var  logic [NG-1:0]              o_general_pin_out,
  output var  logic [NG-1:0]              o_general_pin_oe,
  output var  logic [NG-1:0]              o_general_pin_pull_en,
  output var  logic [NG-1:0]              o_general_pin_pull_up,
  input  wire logic [11:0]                i_awaddr,
  input  wire logic                       i_awvalid,
  output var  logic                       o_awready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  input  wire logic                       i_wvalid,
  output var  logic                       o_wready,
  output var  logic [1:0]                 o_bresp,
  output var  logic                       o_bvalid,
  input  wire logic                       i_bready,
  input  wire logic [11:0]                i_araddr,
  input  wire logic                       i_arvalid,
  output var  logic                       o_arready,
  output var  logic [31:0]                o_rdata,
  output var  logic [1:0]                 o_rresp,
  output var  logic                       o_rvalid,
  input  wire logic                       i_rready
);
  import hub_boot_pkg::*;
  localparam int DW = $clog2(SPI_HALF) + 1;
  localparam int SW = 26 + NG;

  typedef struct packed {
    boot_stage_type state;
    logic [DW-1:0]  div;
    logic [6:0]     bitc;
    logic [63:0]    tx;
    logic [31:0]    rx;
    logic           cs_n, sclk, mosi, ext_rom;
    logic           done, slave, speed;
    logic [5:0]     usb2_off, fixed, charge;
    logic [NG-1:0]  dir, gout, pen, pup;
    logic           aw_held, w_held, awready, wready, bvalid;
    logic [9:0]     aw_idx;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic [1:0]     bresp, rresp;
    logic           arready, rvalid;
    logic [31:0]    rdata;
  } seq_state_type;
  seq_state_type st;
  seq_state_type next_st;

  logic [SW-1:0] sync_out;
  logic [5:0]    plus_s, minus_s;
  logic [2:0]    fixed_s, charge_s, sel_s;
  logic          flash_s, mdata_s, mclk_s, pll_s, miso_s;
  logic [NG-1:0] gpin_s;
  logic          done_hit;

  // every pin input passes the three-stage filter
  pin_sync #(.W(SW)) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pins    ({i_general_pin_n, i_flash_miso, i_pll_locked, i_mgmt_bus_clock_pin,
                 i_mgmt_bus_data_pin, i_flash_boot_strap, i_config_select_strap,
                 i_charging_ports_strap, i_fixed_device_ports_strap,
                 i_port_minus_line_off_strap, i_port_plus_line_off_strap}),
    .o_pins    (sync_out)
  );
  assign {gpin_s, miso_s, pll_s, mclk_s, mdata_s, flash_s, sel_s,
          charge_s, fixed_s, minus_s, plus_s} = sync_out;

  // resistor code to a leading-ports mask, unknown codes give none
  function automatic logic [5:0] port_mask(input logic [2:0] code);
    unique case (code)
      `RC_200K_PU: port_mask = `MASK_P1;
      `RC_10K_PD:  port_mask = `MASK_P12;
      `RC_10K_PU:  port_mask = `MASK_P123;
      `RC_10R_PD:  port_mask = `MASK_P1234;
      `RC_10R_PU:  port_mask = `MASK_ALL;
      default:     port_mask = `MASK_NONE;
    endcase
  endfunction

  // the config-done write is a held write to index FF
  assign done_hit = st.aw_held && st.w_held && !st.bvalid && (st.aw_idx == `IDX_CFG_DONE);

  // boot stages, flash master and register slave
  always_comb begin
    next_st = st;
    unique case (st.state)
      ST_FLASH_INIT: begin
        if (pll_s) begin
          if (flash_s) begin
            next_st.cs_n  = 1'b0;
            next_st.tx    = {`FLASH_READ_CMD, `FLASH_SIG_ADDR, 32'h0000_0000};
            next_st.mosi  = 1'b0;                                 // command msb
            next_st.bitc  = '0;
            next_st.div   = '0;
            next_st.state = ST_FLASH_READ;
          end else begin
            next_st.state = ST_CFG_RD;
          end
        end
      end
      ST_FLASH_READ: begin
        // idle-low clock, sample late in the high phase: mode 0 and 3 parts
        next_st.div = st.div + 1'b1;
        if (st.div == DW'(SPI_HALF - 1)) begin
          next_st.div = '0;
          if (!st.sclk) begin
            next_st.sclk = 1'b1;
          end else begin
            next_st.sclk = 1'b0;
            next_st.rx   = {st.rx[30:0], miso_s};
            next_st.tx   = {st.tx[62:0], 1'b0};
            next_st.mosi = st.tx[62];
            if (st.bitc == `FLASH_LAST_BIT) begin
              next_st.cs_n    = 1'b1;
              next_st.mosi    = 1'b0;
              next_st.ext_rom = ({st.rx[30:0], miso_s} == `FLASH_SIG);
              next_st.state   = ST_CFG_RD;
            end else begin
              next_st.bitc = st.bitc + 1'b1;
            end
          end
        end
      end
      ST_CFG_RD: begin
        // defaults already in place, straps override them once
        next_st.usb2_off = plus_s & minus_s;
        next_st.fixed    = port_mask(fixed_s);
        next_st.charge   = port_mask(charge_s);
        next_st.state    = ST_STRAP;
      end
      ST_STRAP: begin
        if (sel_s == `SEL_OPT2) begin
          next_st.slave = 1'b1;
          next_st.speed = 1'b1;
          next_st.state = (mdata_s && mclk_s) ? ST_SOC_CFG : ST_OTP_CFG;
        end else begin
          next_st.state = ST_OTP_CFG;
        end
      end
      ST_SOC_CFG: begin
        if (done_hit) begin
          next_st.state = ST_OTP_CFG;
        end
      end
      ST_OTP_CFG: begin
        next_st.done  = 1'b1;
        next_st.state = ST_RUN;
      end
      ST_RUN: begin
        next_st.state = ST_RUN;
      end
      default: begin
        next_st.state = ST_FLASH_INIT;
      end
    endcase

    // write address and data are taken in either order
    if (i_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx  = i_awaddr[11:2];
    end
    if (i_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = i_wdata;
      next_st.wstrb  = i_wstrb;
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `RESP_OKAY;
      // general pin setup only once booted, low byte lane
      if (st.state == ST_RUN && st.wstrb[0]) begin
        unique case (st.aw_idx)
          `IDX_GPIO_DIR: next_st.dir  = st.wdata[NG-1:0];
          `IDX_GPIO_OUT: next_st.gout = st.wdata[NG-1:0];
          `IDX_GPIO_PEN: next_st.pen  = st.wdata[NG-1:0];
          `IDX_GPIO_PUP: next_st.pup  = st.wdata[NG-1:0];
          default: ;
        endcase
      end
      unique case (st.aw_idx)
        `IDX_STATUS, `IDX_GPIO_DIR, `IDX_GPIO_OUT, `IDX_GPIO_PEN,
        `IDX_GPIO_PUP, `IDX_GPIO_IN, `IDX_PORTS, `IDX_CFG_DONE: ;
        default: next_st.bresp = `RESP_SLVERR;
      endcase
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;

    // reads answer one cycle after the address is taken
    if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (i_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `RESP_OKAY;
      next_st.rdata  = '0;
      unique case (i_araddr[11:2])
        `IDX_STATUS:   next_st.rdata[6:0] = {st.speed, st.slave, st.done, st.ext_rom,
                                             st.state};
        `IDX_GPIO_DIR: next_st.rdata[NG-1:0] = st.dir;
        `IDX_GPIO_OUT: next_st.rdata[NG-1:0] = st.gout;
        `IDX_GPIO_PEN: next_st.rdata[NG-1:0] = st.pen;
        `IDX_GPIO_PUP: next_st.rdata[NG-1:0] = st.pup;
        `IDX_GPIO_IN:  next_st.rdata[NG-1:0] = gpin_s;
        `IDX_PORTS:    next_st.rdata[17:0]   = {st.charge, st.fixed, st.usb2_off};
        `IDX_CFG_DONE: next_st.rdata[0]      = st.done;
        default:       next_st.rresp         = `RESP_SLVERR;
      endcase
    end
    next_st.arready = !next_st.rvalid;
  end

  // standby: everything returns to defaults and all pins release
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st         <= '0;
      st.state   <= ST_FLASH_INIT;
      st.cs_n    <= 1'b1;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_flash_cs_n          = st.cs_n;
  assign o_flash_sclk          = st.sclk;
  assign o_flash_mosi          = st.mosi;
  assign o_ext_rom_en          = st.ext_rom;
  assign o_stage               = st.state;
  assign o_config_done         = st.done;
  assign o_mgmt_slave_en       = st.slave;
  assign o_speed_ind_en        = st.speed;
  assign o_usb2_port_off       = st.usb2_off;
  assign o_usb3_port_off       = st.usb2_off;
  assign o_fixed_ports         = st.fixed;
  assign o_charging_ports      = st.charge;
  assign o_general_pin_out     = st.gout;
  assign o_general_pin_oe      = st.dir;
  assign o_general_pin_pull_en = st.pen;
  assign o_general_pin_pull_up = st.pup;
  assign o_awready             = st.awready;
  assign o_wready              = st.wready;
  assign o_bresp               = st.bresp;
  assign o_bvalid              = st.bvalid;
  assign o_arready             = st.arready;
  assign o_rdata               = st.rdata;
  assign o_rresp               = st.rresp;
  assign o_rvalid              = st.rvalid;

  // checks beside the logic
  a_port_off_both: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.state == ST_CFG_RD |=> o_usb2_port_off == ($past(plus_s) & $past(minus_s)))
    else $error("port off is not the and of both line straps");
  a_usb3_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_usb3_port_off == o_usb2_port_off)
    else $error("usb3 side does not follow usb2 disable");
  a_fixed_decode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.state == ST_CFG_RD && fixed_s == `RC_10R_PU |=> o_fixed_ports == `MASK_ALL)
    else $error("fixed ports strap decode wrong");
  a_charge_decode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.state == ST_CFG_RD && charge_s == `RC_10K_PD |=> o_charging_ports == `MASK_P12)
    else $error("charging strap decode wrong");
  a_gpio_write_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !$stable(o_general_pin_oe) |-> $past(st.state) == ST_RUN)
    else $error("general pin direction changed before boot ended");
  a_flash_skip: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.state == ST_FLASH_INIT && pll_s && !flash_s |=> st.state == ST_CFG_RD ##1
    st.state == ST_STRAP)
    else $error("unstrapped flash boot did not reach config read");
  a_rom_enable: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_ext_rom_en) |-> $past(st.state) == ST_FLASH_READ && o_flash_cs_n)
    else $error("external rom enabled outside the signature read");
  a_opt2_sense: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.state == ST_STRAP && sel_s == `SEL_OPT2 && mdata_s && mclk_s
    |=> st.state == ST_SOC_CFG && o_mgmt_slave_en)
    else $error("bus pin pull-ups did not enter controller config");
  a_skip_sense: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.state == ST_STRAP && sel_s != `SEL_OPT2 |=> st.state == ST_OTP_CFG ##1
    st.state == ST_RUN)
    else $error("non option 2 did not go straight to otp combine");
  a_soc_wait: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.state == ST_SOC_CFG && !done_hit |=> st.state == ST_SOC_CFG)
    else $error("controller config left without the done write");
  a_straps_held: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st.state == ST_RUN |=> $stable(o_fixed_ports) && $stable(o_usb2_port_off))
    else $error("strap results changed after sampling");
endmodule
`default_nettype wire

// File: verilog/hub_boot_defines.svh
// constants of the boot and strap sequencer
// assumes inclusion by bare name from the design files
`ifndef HUB_BOOT_DEFINES_SVH
`define HUB_BOOT_DEFINES_SVH
// resistor sense codes, in table order
`define RC_200K_PD 3'h0
`define RC_200K_PU 3'h1
`define RC_10K_PD 3'h2
`define RC_10K_PU 3'h3
`define RC_10R_PD 3'h4
`define RC_10R_PU 3'h5
// port masks for none, one to four, and all six ports
`define MASK_NONE 6'h00
`define MASK_P1 6'h01
`define MASK_P12 6'h03
`define MASK_P123 6'h07
`define MASK_P1234 6'h0F
`define MASK_ALL 6'h3F
// config select code for the indicator and slave option
`define SEL_OPT2 3'h1
// serial flash image check
`define FLASH_READ_CMD 8'h03
`define FLASH_SIG_ADDR 24'h00FFFA
`define FLASH_SIG 32'h32444655
`define FLASH_LAST_BIT 7'h3F
// register indexes, byte address is four times the index
`define IDX_STATUS 10'h000
`define IDX_GPIO_DIR 10'h001
`define IDX_GPIO_OUT 10'h002
`define IDX_GPIO_PEN 10'h003
`define IDX_GPIO_PUP 10'h004
`define IDX_GPIO_IN 10'h005
`define IDX_PORTS 10'h006
`define IDX_CFG_DONE 10'h0FF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: verilog/hub_boot_pkg.sv
// types of the boot and strap sequencer
// assumes the defines header is compiled alongside
package hub_boot_pkg;
  typedef enum logic [2:0] {
    ST_FLASH_INIT, ST_FLASH_READ, ST_CFG_RD, ST_STRAP,
    ST_SOC_CFG, ST_OTP_CFG, ST_RUN
  } boot_stage_type;
endpackage

// File: verilog/pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
// assumes i_pins come from outside the i_sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_pins,
  output var  logic [W-1:0] o_pins
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] stable;
  } sync_state_type;
  sync_state_type st;
  sync_state_type next_st;

  // a bit counts once the second and third stages agree
  always_comb begin
    next_st = st;
    next_st.ff1 = i_pins;
    next_st.ff2 = st.ff1;
    next_st.ff3 = st.ff2;
    for (int i = 0; i < W; i++) begin
      if (st.ff2[i] == st.ff3[i]) begin
        next_st.stable[i] = st.ff3[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_pins = st.stable;
endmodule
`default_nettype wire

// File: tb/flash_model.sv
// serial flash partner holding a boot image at the signature address
// assumes the sequencer reads with command 03 in clock mode 0
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic        i_mosi,
  input  wire logic [31:0] i_image_sig,
  output var  logic        o_miso
);
  logic [31:0] req;
  logic [31:0] sh;
  int          cnt;
  initial o_miso = 1'b0;
  // frame start clears the bit count
  always @(negedge i_cs_n) cnt = 0;
  // command and address sampled on the rising clock edge
  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      req = {req[30:0], i_mosi};
      cnt = cnt + 1;
    end
  end
  // image word launched msb first on falling edges, wrong request gets garbage
  always @(negedge i_sclk) begin
    if (!i_cs_n && cnt >= 32) begin
      if (cnt == 32) sh = (req == 32'h0300FFFA) ? i_image_sig : ~i_image_sig;
      o_miso = sh[31];
      sh = {sh[30:0], 1'b0};
    end
  end
  // release of the select line inverts the last bit driven on the line
  always @(posedge i_cs_n) o_miso = ~o_miso;
endmodule
`default_nettype wire

// File: tb/test_hub_boot_strap_sequencer.sv
// self-checking bench for the boot and strap sequencer
// assumes the flash model sits on the serial flash pins
`timescale 1ns/1ps
`default_nettype none
module test_hub_boot_strap_sequencer;
  import hub_boot_pkg::*;
  logic           i_sys_clk, i_rst_n, i_flash_boot_strap, i_pll_locked, i_flash_miso;
  logic           i_mgmt_bus_data_pin, i_mgmt_bus_clock_pin;
  logic [5:0]     i_port_plus_line_off_strap, i_port_minus_line_off_strap;
  logic [2:0]     i_fixed_device_ports_strap, i_charging_ports_strap, i_config_select_strap;
  logic [7:0]     i_general_pin_n, o_general_pin_out, o_general_pin_oe;
  logic [7:0]     o_general_pin_pull_en, o_general_pin_pull_up;
  logic           o_flash_cs_n, o_flash_sclk, o_flash_mosi, o_ext_rom_en, o_config_done;
  logic           o_mgmt_slave_en, o_speed_ind_en;
  logic [5:0]     o_usb2_port_off, o_usb3_port_off, o_fixed_ports, o_charging_ports;
  boot_stage_type o_stage;
  logic [11:0]    i_awaddr, i_araddr;
  logic [31:0]    i_wdata, o_rdata, image_sig, rd;
  logic [3:0]     i_wstrb;
  logic [1:0]     o_bresp, o_rresp, rs;
  logic           i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic           o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  int             n_mismatch, num_checks, cyc;
  logic [5:0]     masks [6] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h3F};

  hub_boot_strap_sequencer #(.NG(8), .SPI_HALF(4)) hub_boot_strap_sequencer_inst (
    .i_sys_clk, .i_rst_n, .i_port_plus_line_off_strap, .i_port_minus_line_off_strap,
    .i_fixed_device_ports_strap, .i_charging_ports_strap, .i_config_select_strap,
    .i_flash_boot_strap, .i_mgmt_bus_data_pin, .i_mgmt_bus_clock_pin, .i_pll_locked,
    .i_flash_miso, .i_general_pin_n, .o_flash_cs_n, .o_flash_sclk, .o_flash_mosi,
    .o_ext_rom_en, .o_stage, .o_config_done, .o_mgmt_slave_en, .o_speed_ind_en,
    .o_usb2_port_off, .o_usb3_port_off, .o_fixed_ports, .o_charging_ports,
    .o_general_pin_out, .o_general_pin_oe, .o_general_pin_pull_en, .o_general_pin_pull_up,
    .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
    .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready);

  flash_model flash_model_inst (.i_cs_n(o_flash_cs_n), .i_sclk(o_flash_sclk),
    .i_mosi(o_flash_mosi), .i_image_sig(image_sig), .o_miso(i_flash_miso));

  // 40 MHz system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // hang guard
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // bus write: both channels offered together, each dropped once taken
  // ready and answer are looked at on the falling edge, where they stand settled
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    logic ad, wd, ta, tw, bv;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_awvalid <= 1'b1;
    i_wdata <= d;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge i_sys_clk);
      ta = (o_awready === 1'b1);
      tw = (o_wready === 1'b1);
      @(posedge i_sys_clk);
      if (!ad && ta) begin
        ad = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!wd && tw) begin
        wd = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge i_sys_clk);
      bv = (o_bvalid === 1'b1);
      rs = o_bresp;
      @(posedge i_sys_clk);
    end while (!bv);
    i_bready <= 1'b0;
  endtask

  // bus read into rd and rs
  task automatic axr(input logic [11:0] a);
    logic ta, rv;
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(negedge i_sys_clk);
      ta = (o_arready === 1'b1);
      @(posedge i_sys_clk);
    end while (!ta);
    i_arvalid <= 1'b0;
    do begin
      @(negedge i_sys_clk);
      rv = (o_rvalid === 1'b1);
      rd = o_rdata;
      rs = o_rresp;
      @(posedge i_sys_clk);
    end while (!rv);
    i_rready <= 1'b0;
  endtask

  // reset pulse with standby check, then release with clock locked
  task automatic boot(input logic fl, input logic [2:0] sel, input logic sd, input logic sc);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    i_pll_locked <= 1'b0;
    i_flash_boot_strap <= fl;
    i_config_select_strap <= sel;
    i_mgmt_bus_data_pin <= sd;
    i_mgmt_bus_clock_pin <= sc;
    repeat (3) @(posedge i_sys_clk);
    chk("standby", {o_stage, o_ext_rom_en, o_usb2_port_off, o_general_pin_oe, o_flash_cs_n},
        {3'h0, 1'h0, 6'h00, 8'h00, 1'h1});
    i_rst_n <= 1'b1;
    i_pll_locked <= 1'b1;
  endtask

  // stage is looked at on the falling edge, away from the edge that moves it
  task automatic ws(input boot_stage_type s);
    do @(negedge i_sys_clk); while (o_stage !== s);
  endtask

  // main sequence
  initial begin
    {i_rst_n, i_pll_locked, i_flash_boot_strap, i_mgmt_bus_data_pin} = 4'h0;
    {i_mgmt_bus_clock_pin, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
    {i_awaddr, i_araddr, i_wdata, i_config_select_strap} = 59'h0;
    {i_fixed_device_ports_strap, i_charging_ports_strap} = 6'h00;
    i_wstrb = 4'hF;
    i_general_pin_n = 8'hA5;
    i_port_plus_line_off_strap = 6'h2B;
    i_port_minus_line_off_strap = 6'h1E;
    image_sig = 32'h32444655;
    {n_mismatch, num_checks, cyc} = 0;
    repeat (20) @(posedge i_sys_clk);
    chk("reset", {o_stage, o_flash_cs_n, o_flash_sclk, o_general_pin_oe, o_awready, o_arready,
        o_bvalid, o_rvalid}, {3'h0, 2'h2, 8'h00, 4'hC});
    // every resistor code on both straps, pull-ups present but option not chosen
    for (int k = 0; k < 6; k++) begin
      i_fixed_device_ports_strap <= 3'(k);
      i_charging_ports_strap <= 3'(5 - k);
      boot(1'b0, 3'h0, 1'b1, 1'b1);
      ws(ST_RUN);
      chk("fixed", o_fixed_ports, masks[k]);
      chk("charge", o_charging_ports, masks[5 - k]);
      chk("off", {o_usb2_port_off, o_usb3_port_off}, {6'h0A, 6'h0A});
      chk("slave", {o_mgmt_slave_en, o_speed_ind_en}, 2'h0);
    end
    // straps moved after boot must not reach the outputs
    i_port_minus_line_off_strap <= 6'h3F;
    i_fixed_device_ports_strap <= 3'h0;
    repeat (10) @(posedge i_sys_clk);
    chk("held", {o_usb2_port_off, o_fixed_ports}, {6'h0A, 6'h3F});
    // flash image with the signature, then without
    boot(1'b1, 3'h0, 1'b0, 1'b0);
    ws(ST_RUN);
    chk("ext rom", o_ext_rom_en, 1'b1);
    axr(12'h000);
    chk("status", {rs, rd}, {2'h0, 32'h0000001E});
    image_sig <= 32'h32444656;
    boot(1'b1, 3'h0, 1'b0, 1'b0);
    ws(ST_RUN);
    chk("no sig", o_ext_rom_en, 1'b0);
    // option two without both pull-ups goes straight on
    boot(1'b0, 3'h1, 1'b1, 1'b0);
    ws(ST_RUN);
    chk("opt2", {o_mgmt_slave_en, o_speed_ind_en}, 2'h3);
    // option two with pull-ups waits for the controller
    boot(1'b0, 3'h1, 1'b1, 1'b1);
    ws(ST_SOC_CFG);
    repeat (200) @(posedge i_sys_clk);
    chk("wait", o_stage, ST_SOC_CFG);
    axw(12'h004, 32'h000000FF);
    chk("early dir", {rs, o_general_pin_oe}, 10'h000);
    axw(12'h3FC, 32'h00000001);
    ws(ST_RUN);
    chk("done", o_config_done, 1'b1);
    // direction, level and pull once running
    axw(12'h004, 32'h0000000F);
    axw(12'h008, 32'h00000005);
    axw(12'h00C, 32'h000000F0);
    axw(12'h010, 32'h00000030);
    chk("pins", {o_general_pin_oe, o_general_pin_out, o_general_pin_pull_en,
        o_general_pin_pull_up}, 32'h0F05F030);
    axr(12'h014);
    chk("pin in", rd, 32'h000000A5);
    axr(12'h3F0);
    chk("unmapped", {rs, rd}, {2'h2, 32'h00000000});
    // reset in mid-run drops the pin setup
    boot(1'b0, 3'h0, 1'b0, 1'b0);
    ws(ST_RUN);
    chk("reboot pins", {o_general_pin_oe, o_general_pin_out, o_general_pin_pull_en,
        o_general_pin_pull_up}, 32'h00000000);
    close_out();
  end
endmodule
`default_nettype wire
